// *** iocc_cfg.svh ***
`ifndef IOCC_CFG_SVH
`define IOCC_CFG_SVH

// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define IOCC_IDX_CTL      8'hb2
`define IOCC_IDX_TRIM     8'hb3
`define IOCC_IDX_CFG      8'hb4

// ----------------------------------------
// Control register field positions
// ----------------------------------------
`define IOCC_CTL_EN       7
`define IOCC_CTL_RDY      6
`define IOCC_CTL_SUSP     5

// ----------------------------------------
// Config register field positions
// ----------------------------------------
`define IOCC_CFG_POL      4
`define IOCC_CFG_PHY      5
`define IOCC_CFG_REC      6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IOCC_CTL_RST      8'h80
`define IOCC_PRESC_RST    2'b00
// Factory trim stand-in, value arbitrary
`define IOCC_TRIM_FACTORY 5'h10

// ----------------------------------------
// Oscillator model timing: base period in clk cycles, settle in oscillator periods
// ----------------------------------------
`define IOCC_OSC_BASE     6'h04
`define IOCC_SETTLE_TICKS 4'h8

`endif

// *** iocc_pkg.sv ***
package iocc_pkg;

	// ----------------------------------------
	// Clock source choice
	// ----------------------------------------
	typedef enum logic [1:0] {
		IOCC_SRC_INT = 2'b00,  // Internal oscillator
		IOCC_SRC_EXT = 2'b01,  // External oscillator
		IOCC_SRC_MUL = 2'b10   // Clock multiplier
	} iocc_src_e;

	// ----------------------------------------
	// APB request bundle
	// ----------------------------------------
	typedef struct packed {
		logic        psel;     // Slave select
		logic        penable;  // Access phase
		logic        pwrite;   // Write when high
		logic [11:0] paddr;    // Byte address
		logic [31:0] pwdata;   // Write data
		logic [3:0]  pstrb;    // Byte lanes
	} iocc_apb_req_s;

	// ----------------------------------------
	// Whole block state
	// ----------------------------------------
	typedef struct packed {
		logic        ctl_en;     // Oscillator enable
		logic        ctl_susp;   // Suspend flag
		logic [1:0]  presc_sel;  // Prescale select
		logic [4:0]  trim;       // Period trim
		iocc_src_e   sys_src;    // Core clock source
		iocc_src_e   usb_src;    // USB clock source
		logic        bus_pol;    // Wake polarity
		logic        phy_en;     // Transceiver on
		logic        rec_en;     // Clock recovery on
		logic [5:0]  per_cnt;    // Period counter
		logic [3:0]  settle;     // Settle counter
		logic        ready;      // Frequency ready
		logic        tick;       // Osc output pulse
		logic [2:0]  div_cnt;    // Prescale counter
		logic        div_pulse;  // Divided pulse
		logic        core_en;    // Core clock enable
		logic        usb_en;     // USB clock enable
		logic        resume;     // Resume pulse
		logic        ni_s1;      // Non-idle sync
		logic        ni_s2;
		logic        ni_s3;
		logic        vb_s1;      // Bus power sync
		logic        vb_s2;
		logic        ex_s1;      // External clock sync
		logic        ex_s2;
		logic        ex_s3;
		logic        mu_s1;      // Multiplier sync
		logic        mu_s2;
		logic        mu_s3;
		logic        mu_half;    // Multiplier halver
		logic        pready;     // APB ready
		logic        pslverr;    // APB error
		logic [7:0]  prdata;     // APB read byte
	} iocc_state_s;

endpackage : iocc_pkg

// *** iocc_top.sv ***
`include "iocc_cfg.svh"

module iocc_top
	import iocc_pkg::*;
(
	input  wire logic          clk_i,                 // 20 MHz clock
	input  wire logic          sys_rst_i,             // Async reset
	input  wire iocc_apb_req_s apb_i,                 // APB request
	output logic [31:0]        prdata_o,              // APB read data
	output logic               pready_o,              // APB ready
	output logic               pslverr_o,             // APB error
	input  wire logic          ext_osc_i,             // External osc level
	input  wire logic          mult_clk_i,            // Multiplier level
	input  wire logic          usb_nonidle_i,         // Non-idle bus
	input  wire logic          bus_power_i,           // Bus power level
	output logic               core_clock_en_o,       // Core clock pulse
	output logic               usb_function_clock_o,  // USB clock pulse
	output logic               resume_irq_o,          // Resume pulse
	output logic               transceiver_enable_o,  // Transceiver on
	output logic               osc_tick_o,            // Internal osc pulse
	output logic [4:0]         osc_period_trim_o      // Trim to oscillator
);

	// ----------------------------------------
	// State and helpers
	// ----------------------------------------
	iocc_state_s st_reg;     // Registered state
	iocc_state_s st_next;    // Next state
	logic        run;        // Oscillator runs
	logic        ext_tick;   // External edge
	logic        mul_tick;   // Multiplier edge
	logic        mul_half;   // Multiplier / 2
	logic        wake_ni;    // Non-idle wake
	logic        wake_vb;    // Bus power wake
	logic        ni_rise;    // Non-idle start
	logic        acc;        // Access phase
	logic        done;       // Transfer completes
	logic        wr_ok;      // Write takes effect
	logic [5:0]  period;     // Period length

	// Byte address of a register index
	function automatic logic [11:0] addr_of(input logic [7:0] idx);
		addr_of = {2'b00, idx, 2'b00};
	endfunction : addr_of

	// Prescale reload for a select value
	function automatic logic [2:0] div_max(input logic [1:0] sel);
		case (sel)
			2'b00:   div_max = 3'h7;  // Divide by 8
			2'b01:   div_max = 3'h3;  // Divide by 4
			2'b10:   div_max = 3'h1;  // Divide by 2
			default: div_max = 3'h0;  // Undivided
		endcase
	endfunction : div_max

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// All behaviour lives here; the flop only registers it
	always_comb begin
		st_next = st_reg;
		// Pulses last one cycle
		st_next.tick      = 1'b0;
		st_next.div_pulse = 1'b0;
		st_next.core_en   = 1'b0;
		st_next.usb_en    = 1'b0;
		st_next.resume    = 1'b0;

		// Synchronisers; first stage feeds only the second
		st_next.ni_s1 = usb_nonidle_i;
		st_next.ni_s2 = st_reg.ni_s1;
		st_next.ni_s3 = st_reg.ni_s2;
		st_next.vb_s1 = bus_power_i;
		st_next.vb_s2 = st_reg.vb_s1;
		st_next.ex_s1 = ext_osc_i;
		st_next.ex_s2 = st_reg.ex_s1;
		st_next.ex_s3 = st_reg.ex_s2;
		st_next.mu_s1 = mult_clk_i;
		st_next.mu_s2 = st_reg.mu_s1;
		st_next.mu_s3 = st_reg.mu_s2;

		// Edges of the foreign clocks
		// Both are free-running levels; the third flop only marks the edge
		ext_tick = st_reg.ex_s2 & ~st_reg.ex_s3;
		mul_tick = st_reg.mu_s2 & ~st_reg.mu_s3;
		// Every second multiplier edge
		mul_half = mul_tick & st_reg.mu_half;
		if (mul_tick) begin
			st_next.mu_half = ~st_reg.mu_half;
		end

		// Oscillator halted when off or suspended
		run    = st_reg.ctl_en & ~st_reg.ctl_susp;
		// Larger trim gives a longer period
		period = `IOCC_OSC_BASE + {1'b0, st_reg.trim};

		// ------------------------------------
		// Internal oscillator model
		// ------------------------------------
		if (!run) begin
			// Stopped: no pulses, ready dropped
			st_next.per_cnt = 6'h00;
			st_next.settle  = 4'h0;
			st_next.ready   = 1'b0;
		end else if (st_reg.per_cnt == period - 6'h01) begin
			st_next.per_cnt = 6'h00;
			st_next.tick    = 1'b1;
			// Ready only after enough full periods
			if (!st_reg.ready) begin
				if (st_reg.settle == `IOCC_SETTLE_TICKS - 4'h1) begin
					st_next.ready = 1'b1;
				end else begin
					st_next.settle = st_reg.settle + 4'h1;
				end
			end
		end else begin
			st_next.per_cnt = st_reg.per_cnt + 6'h01;
		end

		// ------------------------------------
		// Prescaler
		// ------------------------------------
		// Reload picks up a new ratio only on wrap, so no short pulse
		if (st_reg.tick) begin
			if (st_reg.div_cnt == 3'h0) begin
				st_next.div_pulse = 1'b1;
				st_next.div_cnt   = div_max(st_reg.presc_sel);
			end else begin
				st_next.div_cnt = st_reg.div_cnt - 3'h1;
			end
		end

		// ------------------------------------
		// Clock source selection
		// ------------------------------------
		// Code 11 falls back to internal, the source reset picks
		case (st_reg.sys_src)
			IOCC_SRC_EXT: st_next.core_en = ext_tick;
			IOCC_SRC_MUL: st_next.core_en = mul_half;
			default:      st_next.core_en = st_reg.div_pulse;
		endcase
		// Trimmed internal source is software's risk
		case (st_reg.usb_src)
			IOCC_SRC_EXT: st_next.usb_en = ext_tick;
			IOCC_SRC_MUL: st_next.usb_en = mul_tick;
			default:      st_next.usb_en = st_reg.tick;
		endcase

		// ------------------------------------
		// Suspend wake and resume
		// ------------------------------------
		// Detection is not gated by transceiver enable
		wake_ni = st_reg.ni_s2;
		wake_vb = st_reg.vb_s2 == st_reg.bus_pol;
		ni_rise = st_reg.ni_s2 & ~st_reg.ni_s3;
		if (st_reg.ctl_susp && (wake_ni || wake_vb)) begin
			st_next.ctl_susp = 1'b0;
		end
		// Resume while asleep; software then enables transceiver
		if (ni_rise && (st_reg.ctl_susp || !st_reg.phy_en)) begin
			st_next.resume = 1'b1;
		end

		// ------------------------------------
		// APB slave, one wait state
		// ------------------------------------
		acc   = apb_i.psel & apb_i.penable;
		done  = acc & st_reg.pready;
		wr_ok = done & apb_i.pwrite & apb_i.pstrb[0];
		st_next.pready  = acc & ~st_reg.pready;
		st_next.pslverr = 1'b0;
		st_next.prdata  = 8'h00;
		if (acc && !st_reg.pready) begin
			case (apb_i.paddr)
				addr_of(`IOCC_IDX_CTL): begin
					// Unused bits read zero
					st_next.prdata = {st_reg.ctl_en, st_reg.ready,
						st_reg.ctl_susp, 3'b000, st_reg.presc_sel};
				end
				addr_of(`IOCC_IDX_TRIM): begin
					// Recovery owns the trim, hide it
					if (st_reg.rec_en) begin
						st_next.prdata = 8'h00;
					end else begin
						st_next.prdata = {3'b000, st_reg.trim};
					end
				end
				addr_of(`IOCC_IDX_CFG): begin
					st_next.prdata = {1'b0, st_reg.rec_en, st_reg.phy_en,
						st_reg.bus_pol, st_reg.usb_src, st_reg.sys_src};
				end
				default: begin
					// Unmapped address
					st_next.pslverr = 1'b1;
				end
			endcase
		end

		// Writes come last so software wins the cycle
		if (wr_ok) begin
			case (apb_i.paddr)
				addr_of(`IOCC_IDX_CTL): begin
					st_next.ctl_en    = apb_i.pwdata[`IOCC_CTL_EN];
					st_next.presc_sel = apb_i.pwdata[1:0];
					// Writing zero does not leave suspend
					if (apb_i.pwdata[`IOCC_CTL_SUSP]) begin
						st_next.ctl_susp = 1'b1;
					end
				end
				addr_of(`IOCC_IDX_TRIM): begin
					// New period must settle again
					st_next.trim   = apb_i.pwdata[4:0];
					st_next.ready  = 1'b0;
					st_next.settle = 4'h0;
				end
				addr_of(`IOCC_IDX_CFG): begin
					st_next.sys_src = iocc_src_e'(apb_i.pwdata[1:0]);
					st_next.usb_src = iocc_src_e'(apb_i.pwdata[3:2]);
					st_next.bus_pol = apb_i.pwdata[`IOCC_CFG_POL];
					st_next.phy_en  = apb_i.pwdata[`IOCC_CFG_PHY];
					st_next.rec_en  = apb_i.pwdata[`IOCC_CFG_REC];
				end
				default: begin
					// Ignored
					st_next.pslverr = st_next.pslverr;
				end
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Reset restores factory trim and the slow internal clock
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= '{
				ctl_en:    1'(`IOCC_CTL_RST >> `IOCC_CTL_EN),
				presc_sel: `IOCC_PRESC_RST,
				trim:      `IOCC_TRIM_FACTORY,
				sys_src:   IOCC_SRC_INT,
				usb_src:   IOCC_SRC_INT,
				default:   '0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs, all from flops
	// ----------------------------------------
	assign prdata_o             = {24'h000000, st_reg.prdata};
	assign pready_o             = st_reg.pready;
	assign pslverr_o            = st_reg.pslverr;
	assign core_clock_en_o      = st_reg.core_en;
	assign usb_function_clock_o = st_reg.usb_en;
	assign resume_irq_o         = st_reg.resume;
	assign transceiver_enable_o = st_reg.phy_en;
	assign osc_tick_o           = st_reg.tick;
	assign osc_period_trim_o    = st_reg.trim;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// One clock domain; checks pause while reset is high
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Completed write to control with suspend set
	sequence susp_write_q;
		done && apb_i.pwrite && apb_i.pstrb[0]
			&& apb_i.paddr == addr_of(`IOCC_IDX_CTL)
			&& apb_i.pwdata[`IOCC_CTL_SUSP];
	endsequence

	// Read of control in its wait-state cycle, before completion
	sequence ctl_read_q;
		acc && !st_reg.pready && !apb_i.pwrite
			&& apb_i.paddr == addr_of(`IOCC_IDX_CTL);
	endsequence

	reset_values_a: assert property ($past(sys_rst_i) |->
		st_reg.trim == `IOCC_TRIM_FACTORY && st_reg.ctl_en
		&& st_reg.presc_sel == 2'b00 && st_reg.sys_src == IOCC_SRC_INT)
		else $error("reset values wrong");

	halt_no_tick_a: assert property (!run |=> !st_reg.tick)
		else $error("oscillator ticks while halted");

	ready_drop_a: assert property (!run |=> !st_reg.ready)
		else $error("ready high while stopped");

	ready_rise_a: assert property ($rose(st_reg.ready) |-> st_reg.tick
		&& $past(st_reg.settle) == `IOCC_SETTLE_TICKS - 4'h1)
		else $error("ready rose without settling");

	suspend_set_a: assert property (susp_write_q |=> st_reg.ctl_susp ##1 !st_reg.tick)
		else $error("suspend write did not halt");

	wake_clear_a: assert property (st_reg.ctl_susp && (wake_ni || wake_vb) && !wr_ok
		|=> !st_reg.ctl_susp)
		else $error("wake did not clear suspend");

	resume_pulse_a: assert property (ni_rise && st_reg.ctl_susp |=> st_reg.resume
		##1 !st_reg.resume)
		else $error("resume pulse missing");

	presc_load_a: assert property (st_reg.tick && st_reg.div_cnt == 3'h0 |=>
		st_reg.div_pulse && st_reg.div_cnt == div_max($past(st_reg.presc_sel)))
		else $error("prescaler reload wrong");

	presc_hold_a: assert property (st_reg.tick && st_reg.div_cnt != 3'h0
		|=> !st_reg.div_pulse)
		else $error("prescaler pulsed early");

	ctl_unused_a: assert property (ctl_read_q |=> pready_o
		&& prdata_o[4:2] == 3'b000 && !pslverr_o)
		else $error("control unused bits not zero");

	core_src_a: assert property (st_reg.sys_src == IOCC_SRC_INT
		&& !$past(st_reg.div_pulse) && !$past(wr_ok) |-> !st_reg.core_en)
		else $error("core clock pulse without divider");

	// External source passes the synchronised edge straight on
	core_ext_a: assert property (st_reg.sys_src == IOCC_SRC_EXT && !$past(wr_ok)
		|-> st_reg.core_en == $past(ext_tick))
		else $error("core clock does not follow external edge");

	// Internal source gives one USB pulse per oscillator period
	usb_int_a: assert property (st_reg.usb_src == IOCC_SRC_INT && !$past(wr_ok)
		|-> st_reg.usb_en == $past(st_reg.tick))
		else $error("USB clock does not follow oscillator");

	// Without a wake source the oscillator stays halted
	susp_hold_a: assert property (st_reg.ctl_susp && !wake_ni && !wake_vb |=> st_reg.ctl_susp)
		else $error("suspend left without wake");

	// Resume is only ever the echo of a non-idle start
	resume_cause_a: assert property (st_reg.resume |-> $past(ni_rise))
		else $error("resume pulse without bus activity");

	// Completed write to the trim register
	sequence trim_write_q;
		done && apb_i.pwrite && apb_i.pstrb[0]
			&& apb_i.paddr == addr_of(`IOCC_IDX_TRIM);
	endsequence

	// Trim lands in one cycle and forces a new settle
	trim_write_a: assert property (trim_write_q |=>
		st_reg.trim == $past(apb_i.pwdata[4:0]) && !st_reg.ready)
		else $error("trim write not applied");

endmodule : iocc_top

// *** iocc_wake_model.sv ***
// ----------------------------------------
// Transceiver wake and bus power stand-in
// ----------------------------------------
module iocc_wake_model (
	input  wire logic       clk_i,          // System clock
	input  wire logic [1:0] cmd_i,          // 1 resume, 2 power on, 3 power off
	output logic            usb_nonidle_o,  // Non-idle bus level
	output logic            bus_power_o     // Bus power level
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] burst_reg = 3'h0;  // Resume signalling cycles left

	initial begin
		usb_nonidle_o = 1'b0;
		bus_power_o   = 1'b0;
	end

	// Burst is long enough to survive the two-flop synchroniser
	// Signalled whatever the transceiver state, as the bus would
	always @(posedge clk_i) begin
		if (cmd_i == 2'h1)
			burst_reg <= 3'h6;
		else if (burst_reg != 3'h0)
			burst_reg <= burst_reg - 3'h1;
		usb_nonidle_o <= (cmd_i == 2'h1) || (burst_reg > 3'h1);
		if (cmd_i == 2'h2)
			bus_power_o <= 1'b1;
		else if (cmd_i == 2'h3)
			bus_power_o <= 1'b0;
	end
endmodule : iocc_wake_model

// *** internal_osc_clock_control_tb.sv ***
`include "iocc_cfg.svh"

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module internal_osc_clock_control_tb
	import iocc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [11:0] A_CTL  = 12'(`IOCC_IDX_CTL * 4);
	localparam logic [11:0] A_TRIM = 12'(`IOCC_IDX_TRIM * 4);
	localparam logic [11:0] A_CFG  = 12'(`IOCC_IDX_CFG * 4);

	logic          clk_i;
	logic          sys_rst_i  = 1'b1;
	logic          ext_osc_i  = 1'b0;  // Free-running, period 10 cycles
	logic          mult_clk_i = 1'b0;  // Same rate, other phase
	iocc_apb_req_s apb_r      = '0;
	logic [31:0]   prdata_o;
	logic          pready_o, pslverr_o, core_clock_en_o, usb_function_clock_o;
	logic          resume_irq_o, transceiver_enable_o, osc_tick_o;
	logic [4:0]    osc_period_trim_o;
	logic [1:0]    wake_cmd   = 2'h0;
	logic          usb_nonidle, bus_power;
	logic [33:0]   notes[$];           // {check data, error, data}
	logic [33:0]   note;
	int            failures, samples_checked, ticks, cores, usbs, resumes, cyc, n, t, c, u, p, tr;

	iocc_top dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .apb_i(apb_r), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .ext_osc_i(ext_osc_i),
		.mult_clk_i(mult_clk_i), .usb_nonidle_i(usb_nonidle), .bus_power_i(bus_power),
		.core_clock_en_o(core_clock_en_o), .usb_function_clock_o(usb_function_clock_o),
		.resume_irq_o(resume_irq_o), .transceiver_enable_o(transceiver_enable_o),
		.osc_tick_o(osc_tick_o), .osc_period_trim_o(osc_period_trim_o)
	);

	iocc_wake_model wake (
		.clk_i(clk_i), .cmd_i(wake_cmd), .usb_nonidle_o(usb_nonidle), .bus_power_o(bus_power)
	);

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	// Counters use NBA so the sequence reads pre-edge totals without a race
	always @(posedge clk_i) begin
		cyc        <= cyc + 1;
		ext_osc_i  <= (cyc % 10) < 5;
		mult_clk_i <= ((cyc + 3) % 10) < 5;
		if (osc_tick_o === 1'b1) ticks <= ticks + 1;
		if (core_clock_en_o === 1'b1) cores <= cores + 1;
		if (usb_function_clock_o === 1'b1) usbs <= usbs + 1;
		if (resume_irq_o === 1'b1) resumes <= resumes + 1;
		if (pready_o === 1'b1) begin
			if (notes.size() == 0) `CHK("note", 1'b1, 1'b0)
			else begin
				note = notes.pop_front();
				`CHK("pslverr", note[32], pslverr_o)
				if (note[33]) `CHK("prdata", note[31:0], prdata_o)
			end
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task print_verdict();
		$display("Checked %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	// One APB transfer; upper lanes get random junk, which must be ignored
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
		input logic [7:0] e, input logic err);
		int i;
		notes.push_back({~w, err, 24'h0, e});
		@(posedge clk_i);
		apb_r <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: {24'($urandom), d}, pstrb: 4'h1 | 4'($urandom)};
		@(posedge clk_i);
		apb_r.penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (pready_o === 1'b1) break;
		end
		apb_r.psel    <= 1'b0;
		apb_r.penable <= 1'b0;
		if (i == 50) begin
			failures++;
			print_verdict();
		end
	endtask : apb

	// Cycles between two pulses of the core enable or the oscillator tick
	task automatic gap(input logic core, output int g);
		int i, t0;
		t0 = -1;
		for (i = 0; i < 3000; i++) begin
			@(posedge clk_i);
			if ((core ? core_clock_en_o : osc_tick_o) === 1'b1) begin
				if (t0 >= 0) break;
				t0 = i;
			end
		end
		g = i - t0;
		if (i == 3000) begin
			failures++;
			print_verdict();
		end
	endtask : gap

	task automatic wake_send(input logic [1:0] k);
		wake_cmd <= k;
		@(posedge clk_i);
		wake_cmd <= 2'h0;
		repeat (20) @(posedge clk_i);
	endtask : wake_send

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		t = $urandom(10167);
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		`CHK("trim_out", `IOCC_TRIM_FACTORY, osc_period_trim_o)
		apb(A_CTL, 1'b0, 8'h00, 8'h80, 1'b0);
		apb(A_TRIM, 1'b0, 8'h00, {3'h0, `IOCC_TRIM_FACTORY}, 1'b0);
		repeat (200) @(posedge clk_i);
		apb(A_CTL, 1'b0, 8'h00, 8'hc0, 1'b0);
		apb(A_CTL, 1'b1, 8'h9c, 8'h00, 1'b0);
		apb(A_CTL, 1'b0, 8'h00, 8'hc0, 1'b0);
		for (p = 3; p >= 0; p--) begin
			apb(A_CTL, 1'b1, 8'h80 | 8'(p), 8'h00, 1'b0);
			gap(1'b1, n);
			gap(1'b1, n);
			`CHK("core_gap", (4 + `IOCC_TRIM_FACTORY) * (8 >> p), n)
		end
		t = $urandom % 32;
		tr = t;
		apb(A_TRIM, 1'b1, {3'($urandom), 5'(t)}, 8'h00, 1'b0);
		apb(A_CTL, 1'b0, 8'h00, 8'h80, 1'b0);
		apb(A_TRIM, 1'b0, 8'h00, 8'(t), 1'b0);
		`CHK("trim_out", 5'(t), osc_period_trim_o)
		gap(1'b0, n);
		`CHK("osc_gap", 4 + t, n)
		apb(12'h000, 1'b0, 8'h00, 8'h00, 1'b1);
		// Suspend, wake by non-idle signalling, then by bus power
		apb(A_CFG, 1'b1, 8'h10, 8'h00, 1'b0);
		apb(A_CTL, 1'b1, 8'ha3, 8'h00, 1'b0);
		repeat (2) @(posedge clk_i);
		t = ticks;
		repeat (60) @(posedge clk_i);
		`CHK("ticks_susp", t, ticks)
		apb(A_CTL, 1'b0, 8'h00, 8'ha3, 1'b0);
		wake_send(2'h1);
		apb(A_CTL, 1'b0, 8'h00, 8'h83, 1'b0);
		`CHK("resumes", 1, resumes)
		apb(A_CFG, 1'b1, 8'h30, 8'h00, 1'b0); // Software answers resume
		repeat (2) @(posedge clk_i);
		`CHK("phy_en", 1'b1, transceiver_enable_o)
		apb(A_CTL, 1'b1, 8'ha3, 8'h00, 1'b0);
		repeat (20) @(posedge clk_i);
		apb(A_CTL, 1'b0, 8'h00, 8'ha3, 1'b0);
		wake_send(2'h2);
		apb(A_CTL, 1'b0, 8'h00, 8'h83, 1'b0);
		`CHK("resumes", 1, resumes)
		wake_send(2'h3);
		// Trim is no longer factory, so USB runs from the multiplier
		apb(A_CFG, 1'b1, 8'h09, 8'h00, 1'b0);
		c = cores;
		u = usbs;
		repeat (200) @(posedge clk_i);
		`CHK("core_ext", 1'b1, (cores - c) inside {[19:21]})
		`CHK("usb_mult", 1'b1, (usbs - u) inside {[19:21]})
		// Multiplier halved for the core, external edge for USB
		apb(A_CFG, 1'b1, 8'h06, 8'h00, 1'b0);
		c = cores;
		u = usbs;
		repeat (200) @(posedge clk_i);
		`CHK("core_mult", 1'b1, (cores - c) inside {[9:11]})
		`CHK("usb_ext", 1'b1, (usbs - u) inside {[19:21]})
		// Core code 11 falls back to internal; recovery hides the trim
		apb(A_CFG, 1'b1, 8'h43, 8'h00, 1'b0);
		apb(A_CFG, 1'b0, 8'h00, 8'h43, 1'b0);
		apb(A_TRIM, 1'b0, 8'h00, 8'h00, 1'b0);
		c = cores;
		u = usbs;
		repeat (200) @(posedge clk_i);
		`CHK("core_int", 1'b1, (cores - c) inside {[200 / (4 + tr) - 1:200 / (4 + tr) + 1]})
		`CHK("usb_int", 1'b1, (usbs - u) inside {[200 / (4 + tr) - 1:200 / (4 + tr) + 1]})
		// Disable stops the oscillator and drops ready
		apb(A_CTL, 1'b1, 8'h03, 8'h00, 1'b0);
		repeat (2) @(posedge clk_i);
		t = ticks;
		repeat (60) @(posedge clk_i);
		`CHK("ticks_off", t, ticks)
		apb(A_CTL, 1'b0, 8'h00, 8'h03, 1'b0);
		// Second reset in mid-run
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		`CHK("trim_out", `IOCC_TRIM_FACTORY, osc_period_trim_o)
		apb(A_CTL, 1'b0, 8'h00, 8'h80, 1'b0);
		apb(A_TRIM, 1'b0, 8'h00, {3'h0, `IOCC_TRIM_FACTORY}, 1'b0);
		print_verdict();
	end
endmodule : internal_osc_clock_control_tb
